/* File: rtl/tcrb_regs.svh */
// Register offsets, field positions, reset values and timing constants of the register bank
`ifndef TCRB_REGS_SVH
`define TCRB_REGS_SVH
`define TCRB_OFS_SYS        8'h00
`define TCRB_OFS_HEAT_I     8'h01
`define TCRB_OFS_COOL_I     8'h02
`define TCRB_OFS_HEAT_V     8'h03
`define TCRB_OFS_COOL_V     8'h04
`define TCRB_OFS_MOSFET     8'h05
`define TCRB_OFS_ADDR       8'h06
`define TCRB_OFS_CURRENT_MONITOR       8'h07
`define TCRB_OFS_VMON       8'h08
`define TCRB_OFS_STATUS     8'h09
`define TCRB_OFS_ID         8'h0A
`define TCRB_RST_SYS        8'h11
`define TCRB_RST_HEAT_I     8'hA6
`define TCRB_RST_COOL_I     8'hA6
`define TCRB_RST_HEAT_V     8'hDC
`define TCRB_RST_COOL_V     8'h9C
`define TCRB_RST_MOSFET     8'hA5
`define TCRB_RST_ADDR       8'hC0
`define TCRB_MSK_SYS        8'h1F
`define TCRB_MSK_CUR        8'hBF
`define TCRB_MSK_HEAT_V     8'hFF
`define TCRB_MSK_COOL_V     8'hBF
`define TCRB_MSK_MOSFET     8'hFF
`define TCRB_MSK_ADDR       8'hFE
`define TCRB_BIT_ON         0
`define TCRB_BIT_REFRESH    1
`define TCRB_BIT_DIS        4
`define TCRB_BIT_GUARD      7
`define TCRB_BIT_OVP        6
`define TCRB_CUR_STEP_MA    16'd39
`define TCRB_CUR_MAX_CODE   6'h33
`define TCRB_VOLT_STEP_DMV  16'd976
`define TCRB_VOLT_MAX_CODE  6'h38
`define TCRB_LIN_BASE_DA    5'd12
`define TCRB_LIN_STEP_DA    5'd3
`define TCRB_SW_BASE_DA     6'd25
`define TCRB_SW_STEP_DA     6'd5
`define TCRB_DIS_LONG_MS    70
`define TCRB_DIS_SHORT_MS   35
`define TCRB_CLK_KHZ        100000
// Arbitrary neutral identification values
`define TCRB_VENDOR_CODE    4'hA
`define TCRB_VERSION_CODE   4'h5
`endif

/* File: rtl/tcrb_pkg.sv */
// Types shared by the register bank modules
package tcrb_pkg;
	typedef enum logic [8:0] {
		BUS_IDLE  = 9'h001,
		BUS_ADDR  = 9'h002,
		BUS_AACK  = 9'h004,
		BUS_REG   = 9'h008,
		BUS_RACKW = 9'h010,
		BUS_WDATA = 9'h020,
		BUS_WACK  = 9'h040,
		BUS_RDATA = 9'h080,
		BUS_MACK  = 9'h100
	} tcrb_bus_state_t;
	typedef enum logic [2:0] {
		PWR_OFF   = 3'h1,
		PWR_DISCH = 3'h2,
		PWR_RUN   = 3'h4
	} tcrb_pwr_state_t;
endpackage : tcrb_pkg

/* File: rtl/tcrb_line_sampler.sv */
// Bus line sampler giving clock edges and start and stop conditions
module tcrb_line_sampler
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_now,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_det,
	output logic      stop_det
);
	logic scl_q;
	logic sda_q;
	logic scl_p_q;
	logic sda_p_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_q   <= scl_i;
			sda_q   <= sda_i;
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end

	assign sda_now   = sda_q;
	assign scl_rise  = scl_q & ~scl_p_q;
	assign scl_fall  = ~scl_q & scl_p_q;
	assign start_det = scl_q & scl_p_q & sda_p_q & ~sda_q;
	assign stop_det  = scl_q & scl_p_q & ~sda_p_q & sda_q;
endmodule : tcrb_line_sampler

/* File: rtl/tcrb_limit_decode.sv */
// Six-bit limit code to linear limit value, with reserved-code flag
`include "tcrb_regs.svh"
module tcrb_limit_decode
#(
	parameter logic [15:0] STEP     = `TCRB_CUR_STEP_MA,
	parameter logic [5:0]  MAX_CODE = `TCRB_CUR_MAX_CODE
)
(
	input  wire logic [5:0]  code,
	output logic      [15:0] value,
	output logic             reserved
);
	logic [15:0] steps;

	assign steps    = {10'h000, code} + 16'h0001;
	assign value    = steps * STEP;
	assign reserved = code > MAX_CODE;
endmodule : tcrb_limit_decode

/* File: rtl/tcrb_controller_regs.sv */
// Register bank of the cooler controller with its two-wire slave port
`include "tcrb_regs.svh"
module tcrb_controller_regs
	import tcrb_pkg::*;
#(
	parameter int unsigned DIS_LONG_CYC  = `TCRB_DIS_LONG_MS * `TCRB_CLK_KHZ,
	parameter int unsigned DIS_SHORT_CYC = `TCRB_DIS_SHORT_MS * `TCRB_CLK_KHZ
)
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n,
	input  wire logic [55:0] fuse_image,
	input  wire logic [7:0]  adc_current,
	input  wire logic [7:0]  adc_voltage,
	input  wire logic [1:0]  operating_mode,
	input  wire logic        voltage_limit_hit,
	input  wire logic        current_limit_hit,
	input  wire logic        power_stage_active,
	input  wire logic        overtemp_event,
	input  wire logic        thermal_warning,
	input  wire logic [3:0]  mosfet_trip,
	output logic             power_stage_en,
	output logic             discharge_active,
	output logic             stage_running,
	output logic      [3:0]  soft_start_scale,
	output logic             heat_current_guard_en,
	output logic             cool_current_guard_en,
	output logic             heat_voltage_guard_en,
	output logic             cool_voltage_guard_en,
	output logic             input_overvoltage_guard_en,
	output logic      [15:0] heat_current_limit_ma,
	output logic      [15:0] cool_current_limit_ma,
	output logic      [15:0] heat_voltage_limit_dmv,
	output logic      [15:0] cool_voltage_limit_dmv,
	output logic      [3:0]  limit_code_reserved,
	output logic      [4:0]  linear_high_side_limit,
	output logic      [4:0]  linear_low_side_limit,
	output logic      [5:0]  switcher_high_side_limit,
	output logic      [5:0]  switcher_low_side_limit,
	output logic             hiccup_active
);
	// Limits in tenths of an ampere
	function automatic logic [4:0] lin_limit(input logic [1:0] code);
		lin_limit = `TCRB_LIN_BASE_DA + 5'(code * `TCRB_LIN_STEP_DA);
	endfunction : lin_limit

	function automatic logic [5:0] sw_limit(input logic [1:0] code);
		sw_limit = `TCRB_SW_BASE_DA + 6'(code * `TCRB_SW_STEP_DA);
	endfunction : sw_limit

	logic [7:0]      sys_q;
	logic [7:0]      heat_i_q;
	logic [7:0]      cool_i_q;
	logic [7:0]      heat_v_q;
	logic [7:0]      cool_v_q;
	logic [7:0]      mosfet_q;
	logic [7:0]      addr_q;
	logic [7:0]      current_monitor_q;
	logic [7:0]      vmon_q;
	logic [7:0]      status_q;
	logic            ot_latch_q;
	logic            fuse_load_q;
	tcrb_bus_state_t bus_q;
	tcrb_bus_state_t bus_d;
	logic [3:0]      bit_cnt_q;
	logic [7:0]      shift_q;
	logic [7:0]      ptr_q;
	logic            drive_q;
	tcrb_pwr_state_t pwr_q;
	logic [22:0]     dis_cnt_q;
	logic            sda_now;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_det;
	logic            stop_det;
	logic            byte_done;
	logic            addr_match;
	logic            wr_fire;
	logic [7:0]      rd_byte;
	logic [7:0]      status_live;
	logic [7:0]      sys_wr;
	logic [5:0]      lim_code [4];
	logic [15:0]     lim_val [4];
	logic [3:0]      lim_rsv;
	logic [22:0]     dis_len;

	tcrb_line_sampler u_sampler
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.sda_now   (sda_now),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	assign lim_code[0] = heat_i_q[5:0];
	assign lim_code[1] = cool_i_q[5:0];
	assign lim_code[2] = heat_v_q[5:0];
	assign lim_code[3] = cool_v_q[5:0];

	for (genvar g = 0; g < 4; g++)
	begin : g_lim
		tcrb_limit_decode
		#(
			.STEP     (g < 2 ? `TCRB_CUR_STEP_MA : `TCRB_VOLT_STEP_DMV),
			.MAX_CODE (g < 2 ? `TCRB_CUR_MAX_CODE : `TCRB_VOLT_MAX_CODE)
		)
		u_dec
		(
			.code     (lim_code[g]),
			.value    (lim_val[g]),
			.reserved (lim_rsv[g])
		);
	end

	assign byte_done  = scl_fall && (bit_cnt_q == 4'h8);
	assign addr_match = shift_q[7:1] == addr_q[7:1];
	assign wr_fire    = (bus_q == BUS_WDATA) && byte_done;
	assign sys_wr     = shift_q & `TCRB_MSK_SYS;
	assign status_live = {operating_mode, voltage_limit_hit, current_limit_hit,
		power_stage_active, 1'b0, ot_latch_q, thermal_warning};
	assign dis_len    = sys_q[`TCRB_BIT_DIS] ? 23'(DIS_SHORT_CYC - 1)
		: 23'(DIS_LONG_CYC - 1);

	always_comb
	begin
		unique case (ptr_q)
			`TCRB_OFS_SYS:    rd_byte = sys_q;
			`TCRB_OFS_HEAT_I: rd_byte = heat_i_q;
			`TCRB_OFS_COOL_I: rd_byte = cool_i_q;
			`TCRB_OFS_HEAT_V: rd_byte = heat_v_q;
			`TCRB_OFS_COOL_V: rd_byte = cool_v_q;
			`TCRB_OFS_MOSFET: rd_byte = mosfet_q;
			`TCRB_OFS_ADDR:   rd_byte = addr_q;
			`TCRB_OFS_CURRENT_MONITOR:   rd_byte = current_monitor_q;
			`TCRB_OFS_VMON:   rd_byte = vmon_q;
			`TCRB_OFS_STATUS: rd_byte = status_q;
			`TCRB_OFS_ID:     rd_byte = {`TCRB_VENDOR_CODE, `TCRB_VERSION_CODE};
			default:          rd_byte = 8'h00;
		endcase
	end

	// Slave byte engine; sequence
	always_comb
	begin
		bus_d = bus_q;
		unique case (bus_q)
			BUS_IDLE:  bus_d = BUS_IDLE;
			BUS_ADDR:  if (byte_done) bus_d = addr_match ? BUS_AACK : BUS_IDLE;
			BUS_AACK:  if (scl_fall) bus_d = shift_q[0] ? BUS_RDATA : BUS_REG;
			BUS_REG:   if (byte_done) bus_d = BUS_RACKW;
			BUS_RACKW: if (scl_fall) bus_d = BUS_WDATA;
			BUS_WDATA: if (byte_done) bus_d = BUS_WACK;
			BUS_WACK:  if (scl_fall) bus_d = BUS_WDATA;
			BUS_RDATA: if (byte_done) bus_d = BUS_MACK;
			BUS_MACK:
			begin
				if (scl_rise && sda_now)
					bus_d = BUS_IDLE;
				else if (scl_fall)
					bus_d = BUS_RDATA;
			end
			default:   bus_d = BUS_IDLE;
		endcase
		if (stop_det)
			bus_d = BUS_IDLE;
		if (start_det)
			bus_d = BUS_ADDR;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			bus_q     <= BUS_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
			ptr_q     <= 8'h00;
			drive_q   <= 1'b0;
		end
		else
		begin
			bus_q <= bus_d;
			if (start_det || (bus_d != bus_q))
				bit_cnt_q <= 4'h0;
			else if (scl_rise)
				bit_cnt_q <= bit_cnt_q + 4'h1;
			if (scl_rise && (bus_q inside {BUS_ADDR, BUS_REG, BUS_WDATA}))
				shift_q <= {shift_q[6:0], sda_now};
			else if (bus_d == BUS_RDATA && bus_q != BUS_RDATA)
				shift_q <= rd_byte;
			else if (scl_fall && bus_q == BUS_RDATA)
				shift_q <= {shift_q[6:0], 1'b0};
			if (bus_q == BUS_REG && byte_done)
				ptr_q <= shift_q;
			else if (wr_fire || (bus_q == BUS_MACK && scl_fall))
				ptr_q <= ptr_q + 8'h01;
			if (bus_d inside {BUS_AACK, BUS_RACKW, BUS_WACK})
				drive_q <= 1'b1;
			else if (bus_d == BUS_RDATA && bus_q != BUS_RDATA)
				drive_q <= ~rd_byte[7];
			else if (bus_d == BUS_RDATA && scl_fall)
				drive_q <= ~shift_q[6];
			else if (bus_d != BUS_RDATA)
				drive_q <= 1'b0;
		end
	end

	// Register file; fuse image loaded one cycle after reset release
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sys_q       <= `TCRB_RST_SYS;
			heat_i_q    <= `TCRB_RST_HEAT_I;
			cool_i_q    <= `TCRB_RST_COOL_I;
			heat_v_q    <= `TCRB_RST_HEAT_V;
			cool_v_q    <= `TCRB_RST_COOL_V;
			mosfet_q    <= `TCRB_RST_MOSFET;
			addr_q      <= `TCRB_RST_ADDR;
			fuse_load_q <= 1'b1;
		end
		else if (fuse_load_q)
		begin
			sys_q       <= fuse_image[7:0] & `TCRB_MSK_SYS & 8'hFD;
			heat_i_q    <= fuse_image[15:8] & `TCRB_MSK_CUR;
			cool_i_q    <= fuse_image[23:16] & `TCRB_MSK_CUR;
			heat_v_q    <= fuse_image[31:24] & `TCRB_MSK_HEAT_V;
			cool_v_q    <= fuse_image[39:32] & `TCRB_MSK_COOL_V;
			mosfet_q    <= fuse_image[47:40] & `TCRB_MSK_MOSFET;
			addr_q      <= fuse_image[55:48] & `TCRB_MSK_ADDR;
			fuse_load_q <= 1'b0;
		end
		else if (wr_fire)
		begin
			unique case (ptr_q)
				`TCRB_OFS_SYS:    sys_q    <= sys_wr;
				`TCRB_OFS_HEAT_I: heat_i_q <= shift_q & `TCRB_MSK_CUR;
				`TCRB_OFS_COOL_I: cool_i_q <= shift_q & `TCRB_MSK_CUR;
				`TCRB_OFS_HEAT_V: heat_v_q <= shift_q & `TCRB_MSK_HEAT_V;
				`TCRB_OFS_COOL_V: cool_v_q <= shift_q & `TCRB_MSK_COOL_V;
				`TCRB_OFS_MOSFET: mosfet_q <= shift_q & `TCRB_MSK_MOSFET;
				default:          ;
			endcase
		end
		else if (sys_q[`TCRB_BIT_REFRESH])
			sys_q[`TCRB_BIT_REFRESH] <= 1'b0;
	end

	// Status snapshot only on refresh, so software sees one coherent byte
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			status_q   <= 8'h00;
			ot_latch_q <= 1'b0;
			current_monitor_q     <= 8'h80;
			vmon_q     <= 8'h80;
		end
		else
		begin
			ot_latch_q <= ot_latch_q | overtemp_event;
			current_monitor_q     <= adc_current;
			vmon_q     <= adc_voltage;
			if (sys_q[`TCRB_BIT_REFRESH])
				status_q <= status_live;
		end
	end

	// Power sequencing: discharge before each start-up
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pwr_q     <= PWR_OFF;
			dis_cnt_q <= 23'h000000;
		end
		else if (!sys_q[`TCRB_BIT_ON] || fuse_load_q)
			pwr_q <= PWR_OFF;
		else
		begin
			unique case (pwr_q)
				PWR_OFF:
				begin
					pwr_q     <= PWR_DISCH;
					dis_cnt_q <= dis_len;
				end
				PWR_DISCH:
				begin
					if (dis_cnt_q == 23'h000000)
						pwr_q <= PWR_RUN;
					else
						dis_cnt_q <= dis_cnt_q - 23'h000001;
				end
				PWR_RUN:   pwr_q <= PWR_RUN;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sda_o                      <= 1'b0;
			sda_oe_n                   <= 1'b1;
			power_stage_en             <= 1'b0;
			discharge_active           <= 1'b0;
			stage_running              <= 1'b0;
			soft_start_scale           <= 4'h1;
			heat_current_guard_en      <= 1'b0;
			cool_current_guard_en      <= 1'b0;
			heat_voltage_guard_en      <= 1'b0;
			cool_voltage_guard_en      <= 1'b0;
			input_overvoltage_guard_en <= 1'b1;
			heat_current_limit_ma      <= 16'h0000;
			cool_current_limit_ma      <= 16'h0000;
			heat_voltage_limit_dmv     <= 16'h0000;
			cool_voltage_limit_dmv     <= 16'h0000;
			limit_code_reserved        <= 4'h0;
			linear_high_side_limit     <= 5'h00;
			linear_low_side_limit      <= 5'h00;
			switcher_high_side_limit   <= 6'h00;
			switcher_low_side_limit    <= 6'h00;
			hiccup_active              <= 1'b0;
		end
		else
		begin
			sda_oe_n                   <= ~drive_q;
			power_stage_en             <= sys_q[`TCRB_BIT_ON];
			discharge_active           <= pwr_q == PWR_DISCH;
			stage_running              <= pwr_q == PWR_RUN;
			soft_start_scale           <= 4'h1 << sys_q[3:2];
			heat_current_guard_en      <= heat_i_q[`TCRB_BIT_GUARD];
			cool_current_guard_en      <= cool_i_q[`TCRB_BIT_GUARD];
			heat_voltage_guard_en      <= heat_v_q[`TCRB_BIT_GUARD];
			cool_voltage_guard_en      <= cool_v_q[`TCRB_BIT_GUARD];
			input_overvoltage_guard_en <= heat_v_q[`TCRB_BIT_OVP];
			heat_current_limit_ma      <= lim_val[0];
			cool_current_limit_ma      <= lim_val[1];
			heat_voltage_limit_dmv     <= lim_val[2];
			cool_voltage_limit_dmv     <= lim_val[3];
			limit_code_reserved        <= lim_rsv;
			linear_high_side_limit     <= lin_limit(mosfet_q[7:6]);
			linear_low_side_limit      <= lin_limit(mosfet_q[5:4]);
			switcher_high_side_limit   <= sw_limit(mosfet_q[3:2]);
			switcher_low_side_limit    <= sw_limit(mosfet_q[1:0]);
			hiccup_active              <= |mosfet_trip;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_DISCH_LEN: assert property (
		(pwr_q == PWR_DISCH && $past(pwr_q) == PWR_OFF) |->
		dis_cnt_q == ($past(sys_q[`TCRB_BIT_DIS]) ? 23'(DIS_SHORT_CYC - 1) : 23'(DIS_LONG_CYC - 1)))
		else $error("discharge length does not follow its select bit");
	AST_SS_SCALE: assert property (
		(sys_q[3:2] == 2'b11) ##1 (sys_q[3:2] == 2'b11) |-> soft_start_scale == 4'h8)
		else $error("soft-start scale wrong");
	AST_REFRESH_ONCE: assert property (
		sys_q[`TCRB_BIT_REFRESH] && !wr_fire && !fuse_load_q |=>
		!sys_q[`TCRB_BIT_REFRESH] && status_q == $past(status_live))
		else $error("refresh did not update status exactly once");
	AST_POWER_OFF: assert property (
		!sys_q[`TCRB_BIT_ON] |=> pwr_q == PWR_OFF ##1 !stage_running)
		else $error("power stage not off when disabled");
	AST_OT_LATCH: assert property (
		overtemp_event |=> ot_latch_q [*8])
		else $error("over-temperature flag not latched");
	AST_HICCUP: assert property (
		(mosfet_trip != 4'h0) |=> hiccup_active)
		else $error("hiccup not entered on trip");
	AST_COMMIT_ACK: assert property (
		wr_fire |=> bus_q == BUS_WACK ##1 !sda_oe_n)
		else $error("written byte not acknowledged after commit");
	AST_RO_ADDR: assert property (
		(wr_fire && ptr_q == `TCRB_OFS_ADDR) |=> $stable(addr_q))
		else $error("read-only address register changed by write");
	AST_ADDR_MISS: assert property (
		(bus_q == BUS_ADDR && byte_done && !addr_match && !start_det) |=>
		bus_q == BUS_IDLE ##1 sda_oe_n)
		else $error("foreign address acknowledged");

	COV_WRITE: cover property (wr_fire ##[1:40] bus_q == BUS_WACK);
	COV_READ: cover property (bus_q == BUS_MACK ##[1:40] bus_q == BUS_RDATA);
	COV_REFRESH: cover property (wr_fire && ptr_q == `TCRB_OFS_SYS && sys_wr[1]);
	COV_RUN: cover property (pwr_q == PWR_DISCH ##1 pwr_q == PWR_RUN);
endmodule : tcrb_controller_regs

/* File: sim/tcrb_host_model.sv */
// Two-wire bus host model for the register bank
module tcrb_host_model
#(
	parameter logic [6:0] DEV = 7'h60
)
(
	input  wire logic clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_h
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask : gap
	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		sda_h = b;
		gap(5);
		scl = 1'b1;
		gap(5);
		s = sda_w;
		gap(5);
		scl = 1'b0;
		gap(5);
	endtask : bit_io
	// Releasing the line (1) lets the pull-up or the slave decide it
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : xfer
	task automatic start;
		sda_h = 1'b1;
		gap(5);
		scl = 1'b1;
		gap(10);
		sda_h = 1'b0;
		gap(10);
		scl = 1'b0;
		gap(5);
	endtask : start
	task automatic stop;
		sda_h = 1'b0;
		gap(5);
		scl = 1'b1;
		gap(10);
		sda_h = 1'b1;
		gap(10);
	endtask : stop
	task automatic wr(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic       a0, a1, a2;
		start();
		xfer({dev, 1'b0}, q, a0);
		xfer(r, q, a1);
		xfer(d, q, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : wr
	// Single byte read, ended by the host's not-acknowledge
	task automatic rd(input logic [7:0] r, output logic [7:0] q, output logic ok);
		logic a0, a1, a2, a3;
		start();
		xfer({DEV, 1'b0}, q, a0);
		xfer(r, q, a1);
		start();
		xfer({DEV, 1'b1}, q, a2);
		xfer(8'hFF, q, a3);
		stop();
		ok = a0 & a1 & a2;
	endtask : rd
endmodule : tcrb_host_model

/* File: sim/tb_tcrb_controller_regs.sv */
// Self-checking bench for the cooler controller register bank
`include "tcrb_regs.svh"
module tb_tcrb_controller_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [55:0] FUSE = {8'hC0, 8'hA5, 8'h9C, 8'hDC, 8'hA6, 8'hA6, 8'h11};
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        scl, sda_h, sda_o, sda_oe_n, sda_w;
	logic [7:0]  adc_current, adc_voltage;
	logic [1:0]  operating_mode;
	logic        voltage_limit_hit, current_limit_hit;
	logic        power_stage_active, overtemp_event, thermal_warning;
	logic [3:0]  mosfet_trip;
	logic        power_stage_en, discharge_active, stage_running, hiccup_active;
	logic        heat_current_guard_en, cool_current_guard_en, heat_voltage_guard_en;
	logic        cool_voltage_guard_en, input_overvoltage_guard_en;
	logic [3:0]  soft_start_scale, limit_code_reserved;
	logic [15:0] heat_current_limit_ma, cool_current_limit_ma;
	logic [15:0] heat_voltage_limit_dmv, cool_voltage_limit_dmv;
	logic [4:0]  linear_high_side_limit, linear_low_side_limit;
	logic [5:0]  switcher_high_side_limit, switcher_low_side_limit;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          cycles = 0;
	// Open-drain wire with pull-up
	assign sda_w = sda_h & (sda_oe_n | sda_o);
	always #5 clk = ~clk;
	tcrb_host_model #(.DEV(FUSE[55:49])) host (.clk, .sda_w, .scl, .sda_h);
	tcrb_controller_regs #(.DIS_LONG_CYC(400), .DIS_SHORT_CYC(200)) dut (
		.clk, .sys_rst, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_n,
		.fuse_image(FUSE), .adc_current, .adc_voltage, .operating_mode,
		.voltage_limit_hit, .current_limit_hit, .power_stage_active, .overtemp_event,
		.thermal_warning, .mosfet_trip, .power_stage_en, .discharge_active, .stage_running,
		.soft_start_scale, .heat_current_guard_en, .cool_current_guard_en,
		.heat_voltage_guard_en, .cool_voltage_guard_en, .input_overvoltage_guard_en,
		.heat_current_limit_ma, .cool_current_limit_ma, .heat_voltage_limit_dmv,
		.cool_voltage_limit_dmv, .limit_code_reserved, .linear_high_side_limit,
		.linear_low_side_limit, .switcher_high_side_limit, .switcher_low_side_limit,
		.hiccup_active);
	task automatic end_of_test;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rchk(input logic [7:0] r, input logic [7:0] exp);
		logic [7:0] q;
		logic       ok;
		host.rd(r, q, ok);
		check("read ack", ok, 1'b1);
		check("register", q, exp);
	endtask : rchk
	task automatic wchk(input logic [7:0] r, input logic [7:0] d);
		logic ok;
		host.wr(FUSE[55:49], r, d, ok);
		check("write ack", ok, 1'b1);
	endtask : wchk
	// Ceiling well above the roughly 35000 cycles the sequence needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial
	begin
		logic ok;
		adc_current = 8'h3C;
		adc_voltage = 8'hC5;
		operating_mode = 2'h0;
		voltage_limit_hit = 1'b0;
		current_limit_hit = 1'b0;
		power_stage_active = 1'b0;
		overtemp_event = 1'b0;
		thermal_warning = 1'b0;
		mosfet_trip = 4'h0;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		host.gap(4);
		for (int k = 0; k < 7; k++)
			rchk(k[7:0], FUSE[8*k +: 8]);
		rchk(8'h0A, {`TCRB_VENDOR_CODE, `TCRB_VERSION_CODE});
		rchk(8'h07, 8'h3C);
		rchk(8'h08, 8'hC5);
		rchk(8'h09, 8'h00);
		rchk(8'h0B, 8'h00);
		check("power", power_stage_en, 1'b1);
		check("ovp", input_overvoltage_guard_en, 1'b1);
		check("hguard", heat_current_guard_en, 1'b1);
		check("heat ma", heat_current_limit_ma, 16'd1521);
		check("cool ma", cool_current_limit_ma, 16'd1521);
		check("cool dmv", cool_voltage_limit_dmv, 16'd28304);
		check("heat dmv", heat_voltage_limit_dmv, 16'd28304);
		check("cvguard", cool_voltage_guard_en, 1'b1);
		check("lin hs", linear_high_side_limit, 5'd18);
		check("sw ls", switcher_low_side_limit, 6'd30);
		wchk(8'h00, 8'h00);
		check("running", stage_running, 1'b0);
		check("power", power_stage_en, 1'b0);
		wchk(8'h00, 8'h01);
		host.gap(300);
		check("discharge", discharge_active, 1'b1);
		check("running", stage_running, 1'b0);
		host.gap(200);
		check("running", stage_running, 1'b1);
		wchk(8'h00, 8'h00);
		wchk(8'h00, 8'h11);
		host.gap(300);
		check("running", stage_running, 1'b1);
		for (int s = 0; s < 4; s++)
		begin
			wchk(8'h00, {3'h0, 1'b1, s[1:0], 2'h1});
			check("soft start", soft_start_scale, 4'h1 << s);
		end
		wchk(8'h00, 8'hFF);
		rchk(8'h00, 8'h1D);
		host.wr(7'h61, 8'h00, 8'h00, ok);
		check("foreign ack", ok, 1'b0);
		rchk(8'h00, 8'h1D);
		wchk(8'h01, 8'h73);
		rchk(8'h01, 8'h33);
		check("heat ma", heat_current_limit_ma, 16'd2028);
		check("hguard", heat_current_guard_en, 1'b0);
		check("reserved", |limit_code_reserved, 1'b0);
		wchk(8'h02, 8'hB4);
		check("reserved", |limit_code_reserved, 1'b1);
		check("cguard", cool_current_guard_en, 1'b1);
		wchk(8'h02, 8'hA6);
		wchk(8'h04, 8'h78);
		rchk(8'h04, 8'h38);
		check("cool dmv", cool_voltage_limit_dmv, 16'd55632);
		check("vguard", cool_voltage_guard_en, 1'b0);
		check("reserved", |limit_code_reserved, 1'b0);
		wchk(8'h04, 8'h39);
		check("reserved", |limit_code_reserved, 1'b1);
		wchk(8'h03, 8'h9C);
		check("ovp", input_overvoltage_guard_en, 1'b0);
		check("hvguard", heat_voltage_guard_en, 1'b1);
		wchk(8'h05, 8'h1B);
		check("lin hs", linear_high_side_limit, 5'd12);
		check("lin ls", linear_low_side_limit, 5'd15);
		check("sw hs", switcher_high_side_limit, 6'd35);
		check("sw ls", switcher_low_side_limit, 6'd40);
		wchk(8'h05, 8'hE4);
		check("lin hs", linear_high_side_limit, 5'd21);
		check("lin ls", linear_low_side_limit, 5'd18);
		check("sw hs", switcher_high_side_limit, 6'd30);
		check("sw ls", switcher_low_side_limit, 6'd25);
		wchk(8'h06, 8'h00);
		rchk(8'h06, 8'hC0);
		wchk(8'h0A, 8'h00);
		rchk(8'h0A, {`TCRB_VENDOR_CODE, `TCRB_VERSION_CODE});
		operating_mode = 2'h2;
		voltage_limit_hit = 1'b1;
		power_stage_active = 1'b1;
		thermal_warning = 1'b1;
		overtemp_event = 1'b1;
		host.gap(2);
		overtemp_event = 1'b0;
		rchk(8'h09, 8'h00);
		wchk(8'h00, 8'h13);
		rchk(8'h09, 8'hAB);
		operating_mode = 2'h1;
		voltage_limit_hit = 1'b0;
		current_limit_hit = 1'b1;
		power_stage_active = 1'b0;
		thermal_warning = 1'b0;
		rchk(8'h09, 8'hAB);
		wchk(8'h00, 8'h13);
		rchk(8'h09, 8'h52);
		operating_mode = 2'h0;
		current_limit_hit = 1'b0;
		wchk(8'h00, 8'h13);
		rchk(8'h09, 8'h02);
		for (int t = 0; t < 4; t++)
		begin
			mosfet_trip = 4'h1 << t;
			host.gap(2);
			check("hiccup", hiccup_active, 1'b1);
			mosfet_trip = 4'h0;
			host.gap(2);
			check("hiccup", hiccup_active, 1'b0);
		end
		adc_current = 8'h91;
		adc_voltage = 8'h6E;
		rchk(8'h07, 8'h91);
		rchk(8'h08, 8'h6E);
		end_of_test();
	end
endmodule : tb_tcrb_controller_regs
